/* bdt_pkg.sv */
// package: register map, field layout and state types of the buck dead-time / setpoint register bank
package bdt_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] DEAD_TIME_CONTROL_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] VOUT_SETPOINT_COARSE_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] VOUT_SETPOINT_FINE_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] UNDERVOLTAGE_THRESHOLD_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] ANALOG_ENABLE_OFS          = 8'h10;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFS             = 8'h14;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS               = 8'h18;

  // ==========================================================================
  // reset values
  localparam logic [REG_W-1:0] DEAD_TIME_CONTROL_RST      = 8'h00;
  localparam logic [REG_W-1:0] VOUT_SETPOINT_COARSE_RST   = 8'h00;
  localparam logic [REG_W-1:0] VOUT_SETPOINT_FINE_RST     = 8'h00;
  localparam logic [REG_W-1:0] UNDERVOLTAGE_THRESHOLD_RST = 8'h00;
  localparam logic [REG_W-1:0] ANALOG_ENABLE_RST          = 8'h00;
  localparam logic [REG_W-1:0] INT_MASK_RST               = 8'h00;

  // ==========================================================================
  // field positions
  localparam int unsigned HIGH_CODE_MSB     = 7;
  localparam int unsigned HIGH_CODE_LSB     = 4;
  localparam int unsigned LOW_CODE_MSB      = 3;
  localparam int unsigned LOW_CODE_LSB      = 0;
  localparam int unsigned FINE_CODE_MSB     = 4;
  localparam int unsigned DAC_ENABLE_BIT    = 7;
  localparam int unsigned HIGH_BYPASS_BIT   = 1;
  localparam int unsigned LOW_BYPASS_BIT    = 0;
  localparam int unsigned UV_FLAG_BIT       = 0;
  localparam logic [REG_W-1:0] FINE_IMPL_MASK   = 8'h9F;
  localparam logic [REG_W-1:0] ANALOG_IMPL_MASK = 8'h03;
  localparam logic [REG_W-1:0] INT_IMPL_MASK    = 8'h01;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // turn-on delay states
  typedef enum logic [2:0]
  {
    DLY_IDLE = 3'h1,
    DLY_WAIT = 3'h2,
    DLY_ON   = 3'h4
  } bdt_dly_state_t;

endpackage

/* bdt_turn_on_delay.sv */
// turn-on delay of one gate drive signal, falling edge passes at once
`timescale 1ns/10ps

module bdt_turn_on_delay
  import bdt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       driveReq,
  input  wire logic [3:0] delayCode,
  input  wire logic       bypass,
  output logic            gateDrive
);

  bdt_dly_state_t state_q;
  bdt_dly_state_t state_d;
  logic [3:0]     count_q;
  logic [3:0]     count_d;
  logic           drive_q;

  // ==========================================================================
  // delay sequencing
  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      DLY_IDLE:
      begin
        if (driveReq)
        begin
          if (bypass)
            state_d = DLY_ON;
          else
          begin
            state_d = DLY_WAIT;
            count_d = delayCode;
          end
        end
      end
      DLY_WAIT:
      begin
        if (!driveReq)
          state_d = DLY_IDLE;
        else if (count_q == 4'h0)
          state_d = DLY_ON;
        else
          count_d = count_q - 4'h1;
      end
      DLY_ON:
      begin
        if (!driveReq)
          state_d = DLY_IDLE;
      end
      default:
        state_d = DLY_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= DLY_IDLE;
      count_q <= 4'h0;
      drive_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      drive_q <= (state_d == DLY_ON);
    end
  end

  assign gateDrive = drive_q;

endmodule // bdt_turn_on_delay

/* bdt_regs.sv */
// register bank: dead time, output setpoint, undervoltage threshold and flag over AXI4-Lite
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps

module bdt_regs
  import bdt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              highDriveReq,
  input  wire logic              lowDriveReq,
  input  wire logic [REG_W-1:0]  voutSenseCode,
  output logic                   highGateDrive,
  output logic                   lowGateDrive,
  output logic [REG_W-1:0]       setpointCoarseCode,
  output logic [4:0]             setpointFineCode,
  output logic                   setpointDacEnable,
  output logic [REG_W-1:0]       undervoltageLevelCode,
  output logic                   undervoltageIrq
);

  // ==========================================================================
  // address matching on word index
  function automatic logic addrHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    addrHit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // ==========================================================================
  // register map membership, shared by write and read response
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    if (addrHit(addr, DEAD_TIME_CONTROL_OFS))
      isMapped = 1'b1;
    else if (addrHit(addr, VOUT_SETPOINT_COARSE_OFS))
      isMapped = 1'b1;
    else if (addrHit(addr, VOUT_SETPOINT_FINE_OFS))
      isMapped = 1'b1;
    else if (addrHit(addr, UNDERVOLTAGE_THRESHOLD_OFS))
      isMapped = 1'b1;
    else if (addrHit(addr, ANALOG_ENABLE_OFS))
      isMapped = 1'b1;
    else if (addrHit(addr, INT_STATUS_OFS))
      isMapped = 1'b1;
    else if (addrHit(addr, INT_MASK_OFS))
      isMapped = 1'b1;
    else
      isMapped = 1'b0;
  endfunction

  logic [REG_W-1:0]  deadTime_q;
  logic [REG_W-1:0]  coarse_q;
  logic [REG_W-1:0]  fine_q;
  logic [REG_W-1:0]  uvLevel_q;
  logic [REG_W-1:0]  analogEn_q;
  logic [REG_W-1:0]  intMask_q;
  logic              uvFlag_q;
  logic              uvFlag_d;
  logic              awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic [REG_W-1:0]  wData_q;
  logic              wLane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              wrDead;
  logic              wrCoar;
  logic              wrFine;
  logic              wrUv;
  logic              wrAna;
  logic              wrMask;
  logic [REG_W-1:0]  rdByte;

  // ==========================================================================
  // write channel
  wire awTake  = s_axi_awvalid && s_axi_awready;
  wire wTake   = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeld_q && wHeld_q && !bvalid_q;
  wire wrEn    = doWrite && wLane_q;
  wire wrMapped = isMapped(awAddr_q);

  // ==========================================================================
  // write strobe per register
  always_comb
  begin
    wrDead = 1'b0;
    wrCoar = 1'b0;
    wrFine = 1'b0;
    wrUv   = 1'b0;
    wrAna  = 1'b0;
    wrMask = 1'b0;
    if (wrEn)
    begin
      if (addrHit(awAddr_q, DEAD_TIME_CONTROL_OFS))
        wrDead = 1'b1;
      else if (addrHit(awAddr_q, VOUT_SETPOINT_COARSE_OFS))
        wrCoar = 1'b1;
      else if (addrHit(awAddr_q, VOUT_SETPOINT_FINE_OFS))
        wrFine = 1'b1;
      else if (addrHit(awAddr_q, UNDERVOLTAGE_THRESHOLD_OFS))
        wrUv = 1'b1;
      else if (addrHit(awAddr_q, ANALOG_ENABLE_OFS))
        wrAna = 1'b1;
      else if (addrHit(awAddr_q, INT_MASK_OFS))
        wrMask = 1'b1;
    end
  end

  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready  = !wHeld_q && !bvalid_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q  <= 1'b0;
      wData_q  <= '0;
      wLane_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else
    begin
      if (awTake)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata[REG_W-1:0];
        wLane_q <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================================
  // configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deadTime_q <= DEAD_TIME_CONTROL_RST;
      coarse_q   <= VOUT_SETPOINT_COARSE_RST;
      fine_q     <= VOUT_SETPOINT_FINE_RST;
      uvLevel_q  <= UNDERVOLTAGE_THRESHOLD_RST;
      analogEn_q <= ANALOG_ENABLE_RST;
      intMask_q  <= INT_MASK_RST;
    end
    else
    begin
      if (wrDead)
        deadTime_q <= wData_q;
      if (wrCoar)
        coarse_q <= wData_q;
      if (wrFine)
        fine_q <= wData_q & FINE_IMPL_MASK;
      if (wrUv)
        uvLevel_q <= wData_q;
      if (wrAna)
        analogEn_q <= wData_q & ANALOG_IMPL_MASK;
      if (wrMask)
        intMask_q <= wData_q & INT_IMPL_MASK;
    end
  end

  // ==========================================================================
  // read channel
  wire arTake     = s_axi_arvalid && s_axi_arready;
  wire rdStatus   = arTake && addrHit(s_axi_araddr, INT_STATUS_OFS);
  wire [REG_W-1:0] statusWord = {{(REG_W-1){1'b0}}, uvFlag_q};
  wire rdMapped   = isMapped(s_axi_araddr);

  always_comb
  begin
    rdByte = '0;
    if (addrHit(s_axi_araddr, DEAD_TIME_CONTROL_OFS))
      rdByte = deadTime_q;
    else if (addrHit(s_axi_araddr, VOUT_SETPOINT_COARSE_OFS))
      rdByte = coarse_q;
    else if (addrHit(s_axi_araddr, VOUT_SETPOINT_FINE_OFS))
      rdByte = fine_q & FINE_IMPL_MASK;
    else if (addrHit(s_axi_araddr, UNDERVOLTAGE_THRESHOLD_OFS))
      rdByte = uvLevel_q;
    else if (addrHit(s_axi_araddr, ANALOG_ENABLE_OFS))
      rdByte = analogEn_q;
    else if (addrHit(s_axi_araddr, INT_STATUS_OFS))
      rdByte = statusWord;
    else if (addrHit(s_axi_araddr, INT_MASK_OFS))
      rdByte = intMask_q;
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (arTake)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {{(DATA_W-REG_W){1'b0}}, rdByte};
      rresp_q  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ==========================================================================
  // undervoltage flag and interrupt
  wire uvBelow = (voutSenseCode < uvLevel_q);

  assign uvFlag_d = uvBelow || (uvFlag_q && !rdStatus);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      uvFlag_q <= 1'b0;
    else
      uvFlag_q <= uvFlag_d;
  end

  assign undervoltageIrq = uvFlag_q && intMask_q[UV_FLAG_BIT];

  // ==========================================================================
  // analog side outputs
  assign setpointCoarseCode    = coarse_q;
  assign setpointFineCode      = fine_q[FINE_CODE_MSB:0];
  assign setpointDacEnable     = fine_q[DAC_ENABLE_BIT];
  assign undervoltageLevelCode = uvLevel_q;

  // ==========================================================================
  // gate drive turn-on delays
  bdt_turn_on_delay u_high_delay
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .driveReq  (highDriveReq),
    .delayCode (deadTime_q[HIGH_CODE_MSB:HIGH_CODE_LSB]),
    .bypass    (analogEn_q[HIGH_BYPASS_BIT]),
    .gateDrive (highGateDrive)
  );

  bdt_turn_on_delay u_low_delay
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .driveReq  (lowDriveReq),
    .delayCode (deadTime_q[LOW_CODE_MSB:LOW_CODE_LSB]),
    .bypass    (analogEn_q[LOW_BYPASS_BIT]),
    .gateDrive (lowGateDrive)
  );

endmodule // bdt_regs

/* bdt_regs_properties.sv */
// checker: bus handshake, read data, gate drive and flag properties of the register bank
`timescale 1ns/10ps

module bdt_regs_checker
  import bdt_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              highDriveReq,
  input wire logic              lowDriveReq,
  input wire logic              highGateDrive,
  input wire logic              lowGateDrive,
  input wire logic              undervoltageIrq
);
  // ==========================================================================
  // address of the read under way
  logic [ADDR_W-1:0] rdAddr_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) rdAddr_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;

  // ==========================================================================
  // properties
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response not held");
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data not held");
  property p_rAnswer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rAnswer: assert property (p_rAnswer) else $error("read answer late");
  property p_fineGap;
    s_axi_rvalid && rdAddr_q[ADDR_W-1:2] == VOUT_SETPOINT_FINE_OFS[ADDR_W-1:2] |-> s_axi_rdata[6:5] == 2'h0;
  endproperty
  a_fineGap: assert property (p_fineGap) else $error("fine gap bits set");
  property p_highFall;
    !highDriveReq |=> !highGateDrive;
  endproperty
  a_highFall: assert property (p_highFall) else $error("high drive not off");
  property p_lowFall;
    !lowDriveReq |=> !lowGateDrive;
  endproperty
  a_lowFall: assert property (p_lowFall) else $error("low drive not off");
  property p_highRise;
    $rose(highGateDrive) |-> highDriveReq && $past(highDriveReq);
  endproperty
  a_highRise: assert property (p_highRise) else $error("high drive early");
  property p_uvSticky;
    undervoltageIrq && s_axi_awready && !s_axi_awvalid && !s_axi_arvalid |=> undervoltageIrq;
  endproperty
  a_uvSticky: assert property (p_uvSticky) else $error("flag lost");
endmodule // bdt_regs_checker

bind bdt_regs bdt_regs_checker bdt_regs_checker_inst (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .highDriveReq, .lowDriveReq, .highGateDrive, .lowGateDrive, .undervoltageIrq);

/* bdt_regs_bench.sv */
// testbench: register, gate delay, setpoint and undervoltage scenarios
`timescale 1ns/10ps

module bdt_regs_bench import bdt_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, highDriveReq = 1'b0, lowDriveReq = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, voutSenseCode = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic highGateDrive, lowGateDrive, setpointDacEnable, undervoltageIrq;
  logic [7:0] setpointCoarseCode, undervoltageLevelCode;
  logic [4:0] setpointFineCode;
  int nMismatch = 0, numChecks = 0;

  bdt_regs bdt_regs_inst
  (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .highDriveReq(highDriveReq), .lowDriveReq(lowDriveReq), .voutSenseCode(voutSenseCode),
    .highGateDrive(highGateDrive), .lowGateDrive(lowGateDrive), .setpointCoarseCode(setpointCoarseCode),
    .setpointFineCode(setpointFineCode), .setpointDacEnable(setpointDacEnable),
    .undervoltageLevelCode(undervoltageLevelCode), .undervoltageIrq(undervoltageIrq)
  );
  always #25 clk = ~clk;

  // ==========================================================================
  // common tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    rdv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
    chk(rs, RESP_OKAY);
  endtask
  task automatic meas(input logic hi, output int n);
    n = 0;
    highDriveReq <= hi;
    lowDriveReq <= !hi;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((hi ? highGateDrive : lowGateDrive) !== 1'b1 && n < 40);
    highDriveReq <= 1'b0;
    lowDriveReq <= 1'b0;
    repeat (3) @(posedge clk);
    chk(hi ? highGateDrive : lowGateDrive, 32'h0);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    rd(8'h1C);
    chk(rs, RESP_SLVERR);
    wr(8'h1C, 8'hFF);
    chk(rs, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic dly_case(input logic [7:0] code, input int bh, input int bl);
    int dh, dl;
    wr(8'h00, code);
    rdc(8'h00, {24'h0, code});
    meas(1'b1, dh);
    meas(1'b0, dl);
    chk(dh - bh, {28'h0, code[7:4]} + 32'h1);
    chk(dl - bl, {28'h0, code[3:0]} + 32'h1);
  endtask
  task automatic t_delay();
    int bh, bl, dl;
    wr(8'h10, 8'h03);
    meas(1'b1, bh);
    meas(1'b0, bl);
    chk(bh, 32'h2);
    chk(bl, 32'h2);
    wr(8'h10, 8'h00);
    dly_case(8'hA5, bh, bl);
    dly_case(8'h0F, bh, bl);
    wr(8'h10, 8'h01);
    meas(1'b0, dl);
    chk(dl - bl, 32'h0);
    $display("delay test done");
  endtask
  task automatic t_setpoint();
    wr(8'h04, 8'hC5);
    wr(8'h04, 8'h3A, 4'h0);
    rdc(8'h04, 32'hC5);
    chk(setpointCoarseCode, 32'hC5);
    wr(8'h08, 8'hFF);
    rdc(8'h08, 32'h9F);
    chk({setpointDacEnable, setpointFineCode}, 32'h3F);
    wr(8'h08, 8'h60);
    rdc(8'h08, 32'h0);
    chk(setpointDacEnable, 32'h0);
    $display("setpoint test done");
  endtask
  task automatic t_uv();
    wr(8'h0C, 8'h80);
    chk(undervoltageLevelCode, 32'h80);
    wr(8'h18, 8'h01);
    voutSenseCode <= 8'h80;
    repeat (3) @(posedge clk);
    chk(undervoltageIrq, 32'h0);
    voutSenseCode <= 8'h7F;
    repeat (3) @(posedge clk);
    chk(undervoltageIrq, 32'h1);
    voutSenseCode <= 8'h90;
    wr(8'h14, 8'h00);
    chk(undervoltageIrq, 32'h1);
    rdc(8'h14, 32'h1);
    chk(undervoltageIrq, 32'h0);
    rdc(8'h14, 32'h0);
    wr(8'h18, 8'h00);
    voutSenseCode <= 8'h10;
    repeat (3) @(posedge clk);
    chk(undervoltageIrq, 32'h0);
    rdc(8'h14, 32'h1);
    rdc(8'h14, 32'h1);
    $display("undervoltage test done");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_delay();
    t_setpoint();
    t_uv();
    results();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    nMismatch++;
    results();
  end
endmodule // bdt_regs_bench
